// [design/nor_page_sequencer.sv]
// Page-program and flag-clear command handling of a serial NOR flash
//
// What this block does
// RQ1: Command on one, two or four lines
// RQ2: Flag clear ends at any select rise
// RQ3: Opcode 50h clears erase, program, protection errors
// RQ4: Host sets write enable before programming
// RQ5: Host holds select through last data bit
// RQ6: No select rise: nothing executes, latch stays
// RQ7: Address bits taken on clock rise
// RQ8: Protected sector: skip, set flags 1, 4
// RQ9: Timeout clears latch, sets program fail
// RQ10: Decode 02h, A2h, D2h programs
// RQ11: Decode 32h, 38h quad programs
// RQ12: Programming only turns ones into zeros
// RQ13: Write in progress high while programming
// RQ14: Operation end always clears write latch
// RQ15: Status readable while programming
// RQ16: Suspend pauses, resume continues programming
// RQ17: Unaligned data wraps within page
// RQ18: Overflow keeps only last page of bytes
// RQ19: Short page leaves other bytes untouched
// RQ20: Suspend sets flag bit 2
// RQ21: Address phase clock counts per protocol
// RQ22: Page size is a parameter, 256
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`include "nor_prog_cfg.svh"
`timescale 1ns/100ps
module nor_page_sequencer
  import nor_prog_pkg::*;
#(
  parameter int PAGE_BYTES = 256, // Wrap boundary [RQ22]
  parameter int ARRAY_BYTES = 1024,
  parameter int PROG_CYCLES = `PROG_TIME_NS / `CLK_PERIOD_NS,
  parameter int TIMEOUT_CYCLES = `TIMEOUT_NS / `CLK_PERIOD_NS
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic [3:0] i_dq,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_busy
);

  localparam int PW = $clog2(PAGE_BYTES);
  localparam int AW = $clog2(ARRAY_BYTES);

  // Pin synchronisers, stage 0 feeds only stage 1
  logic [1:0] cs_sync_r;
  logic [1:0] sclk_sync_r;
  logic [3:0] dq_meta_r;
  logic [3:0] dq_sync_r;
  logic cs_prev_r;
  logic sclk_prev_r;
  // Frame capture
  phase_t phase_r;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [3:0] bitcnt_r;
  logic [3:0] bitcnt_nxt;
  logic [7:0] opcode_r;
  logic op_valid_r; // Opcode byte complete in this frame
  logic [23:0] addr_r;
  logic [1:0] addr_cnt_r;
  logic [PW-1:0] col_r; // Page column of next data byte
  logic got_data_r;
  logic [7:0] page_buf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] buf_valid_r;
  // Array and sequencer
  logic [7:0] mem [ARRAY_BYTES];
  seq_t seq_r;
  logic [AW:0] idx_r; // Init / commit walk index
  logic [23:0] timer_r;
  logic susp_r;
  logic wel_r;
  logic [7:0] fsr_r; // Sticky error bits and the suspend bit; ready bit built on read
  // Software registers
  logic [31:0] ctrl_r;
  logic [23:0] prog_len_r;
  logic [AW-1:0] arr_addr_r;

  // Decoded strobes
  logic sclk_rise;
  logic cs_rise;
  logic cs_fall;
  logic byte_done;
  logic [2:0] cur_lanes;
  logic [2:0] cmd_lanes;
  logic [2:0] addr_lanes;
  logic [2:0] data_lanes;
  logic is_prog_op;
  logic idle;
  logic prog_go;
  logic [7:0] fsr_view;
  mode_t mode;

  // Two flip-flops on every serial pin before any logic
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      cs_sync_r <= 2'h3;
      sclk_sync_r <= 2'h0;
      dq_meta_r <= 4'h0;
      dq_sync_r <= 4'h0;
      cs_prev_r <= 1'b1;
      sclk_prev_r <= 1'b0;
    end else begin
      cs_sync_r <= {cs_sync_r[0], i_cs_n};
      sclk_sync_r <= {sclk_sync_r[0], i_sclk};
      dq_meta_r <= i_dq;
      dq_sync_r <= dq_meta_r;
      cs_prev_r <= cs_sync_r[1];
      sclk_prev_r <= sclk_sync_r[1];
    end
  end

  // Edges of the synchronised frame signals; bits count only inside a frame
  assign sclk_rise = sclk_sync_r[1] & ~sclk_prev_r & ~cs_sync_r[1]; // [RQ7]
  assign cs_rise = cs_sync_r[1] & ~cs_prev_r;
  assign cs_fall = ~cs_sync_r[1] & cs_prev_r;
  assign idle = (seq_r == SQ_IDLE);
  assign mode = mode_t'(ctrl_r[`CTRL_MODE_LSB +: 2]);

  // Lane count per phase; extended protocol widens only for D2h/38h/A2h/32h
  always_comb begin
    case (mode)
      MODE_DUAL: cmd_lanes = 3'h2;
      MODE_QUAD: cmd_lanes = 3'h4;
      default: cmd_lanes = 3'h1;
    endcase
    addr_lanes = cmd_lanes;
    data_lanes = cmd_lanes;
    if (mode == MODE_EXT) begin // [RQ1]
      if (opcode_r == `OP_XDUAL_PROG) begin
        addr_lanes = 3'h2;
      end else if (opcode_r == `OP_XQUAD_PROG) begin
        addr_lanes = 3'h4;
      end
      if (opcode_r == `OP_DUAL_PROG || opcode_r == `OP_XDUAL_PROG) begin
        data_lanes = 3'h2;
      end else if (opcode_r == `OP_QUAD_PROG || opcode_r == `OP_XQUAD_PROG) begin
        data_lanes = 3'h4;
      end
    end
    case (phase_r)
      PH_CMD: cur_lanes = cmd_lanes;
      PH_ADDR: cur_lanes = addr_lanes; // 24/lanes address clocks [RQ21]
      default: cur_lanes = data_lanes;
    endcase
  end

  // Shift in one, two or four bits, most significant line first
  always_comb begin
    case (cur_lanes)
      3'h4: shift_nxt = {shift_r[3:0], dq_sync_r}; // [RQ1]
      3'h2: shift_nxt = {shift_r[5:0], dq_sync_r[1:0]};
      default: shift_nxt = {shift_r[6:0], dq_sync_r[0]};
    endcase
    bitcnt_nxt = bitcnt_r + {1'b0, cur_lanes};
  end
  assign byte_done = sclk_rise && (bitcnt_nxt == 4'h8);

  // Program opcode decode
  always_comb begin
    case (opcode_r)
      `OP_PAGE_PROG, `OP_DUAL_PROG, `OP_XDUAL_PROG: is_prog_op = 1'b1; // [RQ10]
      `OP_QUAD_PROG, `OP_XQUAD_PROG: is_prog_op = 1'b1; // [RQ11]
      default: is_prog_op = 1'b0;
    endcase
  end

  // Frame phase, opcode and address capture
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      phase_r <= PH_CMD;
      shift_r <= 8'h00;
      bitcnt_r <= 4'h0;
      opcode_r <= 8'h00;
      op_valid_r <= 1'b0;
      addr_r <= 24'h000000;
      addr_cnt_r <= 2'h0;
      got_data_r <= 1'b0;
    end else if (cs_fall) begin // New frame restarts the decoder
      phase_r <= PH_CMD;
      bitcnt_r <= 4'h0;
      op_valid_r <= 1'b0;
      addr_cnt_r <= 2'h0;
      got_data_r <= 1'b0;
    end else if (sclk_rise) begin
      shift_r <= shift_nxt;
      bitcnt_r <= byte_done ? 4'h0 : bitcnt_nxt;
      if (byte_done) begin
        case (phase_r)
          PH_CMD: begin
            opcode_r <= shift_nxt;
            op_valid_r <= 1'b1;
            case (shift_nxt)
              `OP_PAGE_PROG, `OP_DUAL_PROG, `OP_XDUAL_PROG,
              `OP_QUAD_PROG, `OP_XQUAD_PROG: phase_r <= PH_ADDR;
              default: phase_r <= PH_SKIP; // Other commands take no payload here
            endcase
          end
          PH_ADDR: begin
            addr_r <= {addr_r[15:0], shift_nxt}; // [RQ7]
            addr_cnt_r <= addr_cnt_r + 2'h1;
            if (addr_cnt_r == `ADDR_BYTES - 2'h1) begin
              phase_r <= PH_DATA;
            end
          end
          PH_DATA: got_data_r <= 1'b1;
          default: phase_r <= PH_SKIP;
        endcase
      end
    end
  end

  // Page buffer; frozen while the array is busy so a stray frame cannot corrupt it
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      col_r <= '0;
      buf_valid_r <= '0;
    end else if (idle && cs_fall) begin
      buf_valid_r <= '0; // Untouched bytes stay unwritten [RQ19]
    end else if (idle && byte_done) begin
      if (phase_r == PH_ADDR && addr_cnt_r == `ADDR_BYTES - 2'h1) begin
        col_r <= shift_nxt[PW-1:0]; // Start column from low address bits
      end else if (phase_r == PH_DATA) begin
        page_buf[col_r] <= shift_nxt; // Later bytes overwrite earlier ones [RQ18]
        buf_valid_r[col_r] <= 1'b1;
        col_r <= col_r + 1'b1; // Wraps to page start [RQ17]
      end
    end
  end

  // A program command is taken only at select rise on a byte boundary
  assign prog_go = cs_rise && op_valid_r && is_prog_op && phase_r == PH_DATA &&
                   got_data_r && bitcnt_r == 4'h0 && wel_r && idle; // [RQ4] [RQ5] [RQ6]

  // Array sequencer: erased fill after reset, then page commits
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      seq_r <= SQ_INIT;
      idx_r <= '0;
      timer_r <= 24'h000000;
    end else begin
      case (seq_r)
        SQ_INIT: begin
          idx_r <= idx_r + 1'b1;
          if (idx_r == (AW+1)'(ARRAY_BYTES - 1)) begin
            seq_r <= SQ_IDLE;
          end
        end
        SQ_IDLE: begin
          idx_r <= '0;
          timer_r <= 24'h000000;
          if (prog_go && !ctrl_r[`CTRL_PROT_LSB + addr_r[23:21]]) begin
            seq_r <= SQ_PROG;
          end
        end
        SQ_PROG: begin
          if (!susp_r) begin // Suspend freezes time and commit [RQ16]
            timer_r <= timer_r + 24'h000001;
            if (idx_r < (AW+1)'(PAGE_BYTES)) begin
              idx_r <= idx_r + 1'b1;
            end
            if (timer_r >= 24'(TIMEOUT_CYCLES)) begin // [RQ9]
              seq_r <= SQ_IDLE;
            end else if (idx_r >= (AW+1)'(PAGE_BYTES) && timer_r >= prog_len_r) begin
              seq_r <= SQ_IDLE; // [RQ13]
            end
          end
        end
        default: seq_r <= SQ_IDLE;
      endcase
    end
  end

  // Array writes: all ones at start, then AND with valid buffer bytes
  always_ff @(posedge i_mclk) begin
    if (seq_r == SQ_INIT) begin
      mem[idx_r[AW-1:0]] <= 8'hff;
    end else if (seq_r == SQ_PROG && !susp_r && idx_r < (AW+1)'(PAGE_BYTES)) begin
      if (buf_valid_r[idx_r[PW-1:0]]) begin
        mem[{addr_r[AW-1:PW], idx_r[PW-1:0]}] <=
          mem[{addr_r[AW-1:PW], idx_r[PW-1:0]}] & page_buf[idx_r[PW-1:0]]; // [RQ12]
      end
    end
  end

  // Write enable latch
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      wel_r <= 1'b0;
    end else if (seq_r == SQ_PROG && seq_r != SQ_IDLE && !susp_r &&
                 (timer_r >= 24'(TIMEOUT_CYCLES) ||
                  (idx_r >= (AW+1)'(PAGE_BYTES) && timer_r >= prog_len_r))) begin
      wel_r <= 1'b0; // Cleared on success and failure [RQ14] [RQ9]
    end else if (cs_rise && op_valid_r && idle) begin
      if (opcode_r == `OP_WR_ENABLE) begin
        wel_r <= 1'b1;
      end else if (opcode_r == `OP_WR_DISABLE) begin
        wel_r <= 1'b0;
      end
    end
  end

  // Suspend state; ignored when nothing runs
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      susp_r <= 1'b0;
    end else if (seq_r != SQ_PROG) begin
      susp_r <= 1'b0;
    end else if (cs_rise && op_valid_r && opcode_r == `OP_SUSPEND) begin
      susp_r <= 1'b1; // [RQ16]
    end else if (cs_rise && op_valid_r && opcode_r == `OP_RESUME) begin
      susp_r <= 1'b0; // [RQ16]
    end
  end

  // Flag status bits; sets are placed after the clear so they win
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      fsr_r <= 8'h00;
    end else begin
      if (cs_rise && op_valid_r && opcode_r == `OP_CLR_FLAGS) begin // [RQ2]
        fsr_r[`FSR_ERASE_ERR] <= 1'b0; // [RQ3]
        fsr_r[`FSR_PROG_ERR] <= 1'b0;
        fsr_r[`FSR_PROT_ERR] <= 1'b0;
      end
      if (prog_go && ctrl_r[`CTRL_PROT_LSB + addr_r[23:21]]) begin
        fsr_r[`FSR_PROT_ERR] <= 1'b1; // Latch untouched, nothing runs [RQ8]
        fsr_r[`FSR_PROG_ERR] <= 1'b1;
      end
      if (seq_r == SQ_PROG && !susp_r && timer_r >= 24'(TIMEOUT_CYCLES)) begin
        fsr_r[`FSR_PROG_ERR] <= 1'b1; // [RQ9]
      end
      if (seq_r != SQ_PROG) begin
        fsr_r[`FSR_PROG_SUSP] <= 1'b0;
      end else if (cs_rise && op_valid_r && opcode_r == `OP_SUSPEND) begin
        fsr_r[`FSR_PROG_SUSP] <= 1'b1; // [RQ20]
      end else if (cs_rise && op_valid_r && opcode_r == `OP_RESUME) begin
        fsr_r[`FSR_PROG_SUSP] <= 1'b0;
      end
    end
  end

  // Ready reads 1 when idle or suspended
  always_comb begin
    fsr_view = fsr_r;
    fsr_view[`FSR_READY] = (seq_r != SQ_PROG) || susp_r;
  end

  // Software-written registers
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      ctrl_r <= `CTRL_RESET;
      prog_len_r <= 24'(PROG_CYCLES);
      arr_addr_r <= '0;
    end else if (i_wr) begin
      if (i_addr == `REG_CTRL) begin
        ctrl_r <= i_wdata & 32'h0000ff03;
      end else if (i_addr == `REG_PROG_LEN) begin
        prog_len_r <= i_wdata[23:0];
      end else if (i_addr == `REG_ARR_ADDR) begin
        arr_addr_r <= i_wdata[AW-1:0];
      end
    end
  end

  // Read data valid only in the cycle after the strobe; polling never blocked
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      o_rdata <= 32'h00000000;
    end else if (!i_rd) begin
      o_rdata <= 32'h00000000;
    end else if (i_addr == `REG_CTRL) begin
      o_rdata <= ctrl_r;
    end else if (i_addr == `REG_STATUS) begin // [RQ15]
      o_rdata <= {30'h0, wel_r, seq_r == SQ_PROG};
    end else if (i_addr == `REG_FLAGS) begin // [RQ15]
      o_rdata <= {24'h0, fsr_view};
    end else if (i_addr == `REG_PROG_LEN) begin
      o_rdata <= {8'h00, prog_len_r};
    end else if (i_addr == `REG_ARR_ADDR) begin
      o_rdata <= {{(32-AW){1'b0}}, arr_addr_r};
    end else if (i_addr == `REG_ARR_DATA) begin
      o_rdata <= {24'h0, mem[arr_addr_r]};
    end else begin
      o_rdata <= 32'h00000000; // Unmapped reads zero
    end
  end

  // Busy follows the sequencer one cycle late: high while it is not idle, also during the erased fill
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      o_busy <= 1'b1;
    end else begin
      o_busy <= (seq_r != SQ_IDLE); // [RQ13]
    end
  end

endmodule // nor_page_sequencer

// [design/nor_prog_cfg.svh]
// Constants of the page-program sequencer
`ifndef NOR_PROG_CFG_SVH
`define NOR_PROG_CFG_SVH
// Opcodes
`define OP_PAGE_PROG 8'h02
`define OP_DUAL_PROG 8'ha2
`define OP_XDUAL_PROG 8'hd2
`define OP_QUAD_PROG 8'h32
`define OP_XQUAD_PROG 8'h38
`define OP_CLR_FLAGS 8'h50
`define OP_WR_ENABLE 8'h06
`define OP_WR_DISABLE 8'h04
`define OP_SUSPEND 8'h75
`define OP_RESUME 8'h7a
// Address bytes of a program frame
`define ADDR_BYTES 2'h3
// Register byte addresses
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_FLAGS 8'h08
`define REG_PROG_LEN 8'h0c
`define REG_ARR_ADDR 8'h10
`define REG_ARR_DATA 8'h14
// Control fields
`define CTRL_MODE_LSB 0
`define CTRL_PROT_LSB 8
`define CTRL_RESET 32'h00000000
// Flag status bit positions
`define FSR_READY 7
`define FSR_ERASE_ERR 5
`define FSR_PROG_ERR 4
`define FSR_PROG_SUSP 2
`define FSR_PROT_ERR 1
// Status bit positions
`define SR_WIP 0
`define SR_WEL 1
// Timing
`define CLK_PERIOD_NS 20
`define PROG_TIME_NS 200000
`define TIMEOUT_NS 2000000
`endif

// [design/nor_prog_pkg.sv]
// Types of the page-program sequencer
package nor_prog_pkg;
  // Serial frame phase
  typedef enum logic [3:0] {
    PH_CMD = 4'b0001,
    PH_ADDR = 4'b0010,
    PH_DATA = 4'b0100,
    PH_SKIP = 4'b1000
  } phase_t;
  // Array sequencer state
  typedef enum logic [2:0] {
    SQ_INIT = 3'b001,
    SQ_IDLE = 3'b010,
    SQ_PROG = 3'b100
  } seq_t;
  // Protocol selected by software
  typedef enum logic [1:0] {
    MODE_EXT = 2'b00,
    MODE_DUAL = 2'b01,
    MODE_QUAD = 2'b10
  } mode_t;
endpackage

// [tb/nor_page_sequencer_chk.sv]
// Port-level assertions of the page-program sequencer
`include "nor_prog_cfg.svh"
`timescale 1ns/100ps
module nor_page_sequencer_chk (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic [3:0] i_dq,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic o_busy
);
  // One domain, so clock and reset are given once
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  // Read data stand for one cycle only, zero otherwise
  rdata_idle_a: assert property (!i_rd |=> o_rdata == 32'h0)
    else $error("read data not zero outside a read");
  // Array fill keeps the block busy right after reset
  fill_busy_a: assert property ($rose(i_reset_n) |-> o_busy [*8])
    else $error("busy low during fill");
  status_bits_a: assert property (i_rd && i_addr == `REG_STATUS
    |=> o_rdata[31:2] == 30'h0)
    else $error("status read has stray bits");
  flags_bits_a: assert property (i_rd && i_addr == `REG_FLAGS
    |=> o_rdata[31:8] == 24'h0)
    else $error("flag read has stray bits");
  unmapped_read_a: assert property (i_rd && i_addr == 8'h40 |=> o_rdata == 32'h0)
    else $error("unmapped read not zero");
  // Busy lags the sequencer by one cycle, so busy low in the answer cycle
  // proves the sequencer was idle when the read was taken
  idle_wip_a: assert property ((i_rd && i_addr == `REG_STATUS) ##1 !o_busy
    |-> !o_rdata[`SR_WIP])
    else $error("write in progress set while idle");
  idle_ready_a: assert property ((i_rd && i_addr == `REG_FLAGS) ##1 !o_busy
    |-> o_rdata[`FSR_READY])
    else $error("ready low while idle");
  arr_byte_a: assert property (i_rd && i_addr == `REG_ARR_DATA |=> o_rdata[31:8] == 24'h0)
    else $error("array read wider than a byte");
  len_width_a: assert property (i_rd && i_addr == `REG_PROG_LEN |=> o_rdata[31:24] == 8'h0)
    else $error("length read wider than 24 bits");
endmodule // nor_page_sequencer_chk

bind nor_page_sequencer nor_page_sequencer_chk u_chk (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
  .i_cs_n(i_cs_n), .i_sclk(i_sclk), .i_dq(i_dq), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_busy(o_busy));

// [tb/spi_host_model.sv]
// Host-side serial flash controller model driving select, clock and data lines
`timescale 1ns/100ps
module spi_host_model (
  input wire logic i_clk,
  output logic o_cs_n,
  output logic o_sclk,
  output logic [3:0] o_dq
);
  // Serial clock rests low outside frames
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_dq = 4'h0;
  end
  // Select low, then a setup gap
  task automatic start();
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask
  // MSB first over ln lanes; four mclk per phase keeps the sync margin
  task automatic put(input logic [7:0] b, input int ln, input int nb);
    for (int i = 8; i > 8 - nb; i -= ln) begin
      o_dq <= 4'(({24'h0, b} >> (i - ln)) & ((32'h1 << ln) - 1));
      repeat (4) @(posedge i_clk);
      o_sclk <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_sclk <= 1'b0;
    end
  endtask
  // Select rises only after the last bit; released lines show the inverse value
  task automatic stop();
    repeat (4) @(posedge i_clk);
    o_cs_n <= 1'b1;
    o_dq <= ~o_dq;
    repeat (8) @(posedge i_clk);
  endtask
endmodule // spi_host_model

// [tb/tb_nor_page_sequencer.sv]
// Self-checking bench of the page-program sequencer
`include "nor_prog_cfg.svh"
`timescale 1ns/100ps
module tb_nor_page_sequencer
  import nor_prog_pkg::*;
;
  logic i_mclk, i_reset_n, i_wr, i_rd, o_busy, cs_n, sclk;
  logic [3:0] dq;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata;
  logic [7:0] mem [1024]; // Expected array contents
  logic [9:0] a; // Start of the current program
  logic [7:0] ops [5] = '{8'h02, 8'ha2, 8'hd2, 8'h32, 8'h38};
  int las [5] = '{1, 1, 2, 1, 4}; // Address lanes per opcode
  int lds [5] = '{1, 2, 2, 4, 4}; // Data lanes per opcode
  int lc; // Command lanes of the current mode
  int n_mismatch = 0;
  int check_count = 0;
  // Short program time so the run stays brief
  nor_page_sequencer #(.PROG_CYCLES(300), .TIMEOUT_CYCLES(500)) u_dut (.i_mclk(i_mclk),
    .i_reset_n(i_reset_n), .i_cs_n(cs_n), .i_sclk(sclk), .i_dq(dq), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_busy(o_busy));
  spi_host_model u_host (.i_clk(i_mclk), .o_cs_n(cs_n), .o_sclk(sclk), .o_dq(dq));
  // 50 MHz clock
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= ad;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  // Data are taken in the one cycle after the strobe
  task automatic rdc(input logic [7:0] ad, input logic [31:0] exp);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= ad;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(negedge i_mclk);
    check(o_rdata, exp);
  endtask
  task automatic arr(input logic [9:0] ad);
    wr(`REG_ARR_ADDR, {22'h0, ad});
    rdc(`REG_ARR_DATA, {24'h0, mem[ad]});
  endtask
  // Bounded wait for the array to go idle; running out counts as a mismatch
  task automatic idle();
    int k;
    k = 0;
    while (o_busy !== 1'b0 && k < 20000) begin
      @(negedge i_mclk); // Busy is looked at where it has settled
      k++;
    end
    if (k == 20000) n_mismatch++;
  endtask
  // Command-only frame with xb extra bits before select rises
  task automatic cmd(input logic [7:0] op, input int xb);
    u_host.start();
    u_host.put(op, lc, 8);
    if (xb > 0) u_host.put(8'h5a, lc, xb);
    u_host.stop();
  endtask
  // Program frame; the model keeps the last byte per column, then ANDs it in
  task automatic frame(input int k, input logic [23:0] ad, input int nb, input int xb,
    input bit ok);
    logic [7:0] pg [256];
    bit tch [256];
    logic [7:0] d;
    int la;
    int ld;
    // Dual and quad protocols carry every phase on all of their lanes
    la = (lc > 1) ? lc : las[k];
    ld = (lc > 1) ? lc : lds[k];
    u_host.start();
    u_host.put(ops[k], lc, 8);
    for (int i = 0; i < 3; i++) u_host.put(8'(ad >> (16 - 8 * i)), la, 8);
    for (int n = 0; n < nb; n++) begin
      d = 8'($urandom);
      u_host.put(d, ld, 8);
      pg[8'(ad[7:0] + 8'(n))] = d;
      tch[8'(ad[7:0] + 8'(n))] = 1'b1;
    end
    if (xb > 0) u_host.put(8'h00, ld, xb);
    u_host.stop();
    if (ok) for (int c = 0; c < 256; c++) if (tch[c]) mem[{ad[9:8], 8'(c)}] &= pg[c];
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog about four times the expected run length, inside the cycle budget
  initial begin
    repeat (60000) @(posedge i_mclk);
    n_mismatch++;
    summarize();
  end
  initial begin
    {i_reset_n, i_wr, i_rd, i_addr, i_wdata} = '0;
    lc = 1;
    foreach (mem[i]) mem[i] = 8'hff;
    void'($urandom(85));
    repeat (4) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    @(negedge i_mclk);
    check({31'h0, o_busy}, 32'h1);
    rdc(`REG_FLAGS, 32'h80);
    rdc(`REG_PROG_LEN, 32'd300);
    rdc(8'h40, 32'h0);
    wr(`REG_STATUS, 32'h3); // Read-only, must be ignored
    idle();
    rdc(`REG_STATUS, 32'h0);
    // Program without write enable is dropped
    frame(0, 24'h000010, 4, 0, 0);
    rdc(`REG_STATUS, 32'h0);
    arr(10'h010);
    // Write disable drops the latch again
    cmd(8'h06, 0);
    rdc(`REG_STATUS, 32'h2);
    cmd(8'h04, 0);
    rdc(`REG_STATUS, 32'h0);
    // Every opcode, start in the last eight bytes of a page so data can wrap
    for (int k = 0; k < 5; k++) begin
      cmd(8'h06, 0);
      a = 10'($urandom) | 10'h0f8;
      frame(k, {14'h0, a}, 1 + $urandom % 6, 0, 1);
      rdc(`REG_STATUS, 32'h3);
      rdc(`REG_FLAGS, 32'h0);
      idle();
      rdc(`REG_STATUS, 32'h0);
      for (int j = 0; j < 8; j++) arr({a[9:8], 8'(a[7:0] + 8'(j))});
    end
    // Dual mode carries the command on two lanes
    wr(`REG_CTRL, 32'h1);
    lc = 2;
    cmd(8'h06, 0);
    frame(1, 24'h000300, 3, 0, 1);
    idle();
    for (int j = 0; j < 4; j++) arr(10'h300 + 10'(j));
    // Quad mode overflow: only the last page of bytes counts
    wr(`REG_CTRL, 32'h2);
    lc = 4;
    cmd(8'h06, 0);
    frame(3, {16'h0001, 8'($urandom)}, 258, 0, 1);
    idle();
    for (int j = 0; j < 256; j++) arr({2'h1, 8'(j)});
    wr(`REG_CTRL, 32'h0);
    lc = 1;
    rdc(`REG_CTRL, 32'h0);
    // Select rises off a byte boundary: nothing runs, latch stays
    cmd(8'h06, 0);
    frame(0, 24'h000200, 1, 5, 0);
    rdc(`REG_STATUS, 32'h2);
    rdc(`REG_FLAGS, 32'h80);
    // Protected region seven
    wr(`REG_CTRL, 32'h8000);
    frame(0, 24'he00200, 2, 0, 0);
    rdc(`REG_FLAGS, 32'h92);
    rdc(`REG_STATUS, 32'h2);
    arr(10'h200);
    wr(`REG_CTRL, 32'h0);
    cmd(8'h50, 3);
    rdc(`REG_FLAGS, 32'h80);
    // Program longer than the timeout
    wr(`REG_PROG_LEN, 32'd600);
    frame(0, 24'h000280, 2, 0, 0);
    idle();
    rdc(`REG_FLAGS, 32'h90);
    rdc(`REG_STATUS, 32'h0);
    cmd(8'h50, 0);
    wr(`REG_PROG_LEN, 32'd300);
    // Suspend and resume in mid-program
    cmd(8'h06, 0);
    frame(0, 24'h000040, 2, 0, 1);
    cmd(8'h75, 0);
    rdc(`REG_FLAGS, 32'h84);
    repeat (50) @(posedge i_mclk);
    rdc(`REG_STATUS, 32'h3);
    cmd(8'h7a, 0);
    rdc(`REG_FLAGS, 32'h0);
    idle();
    rdc(`REG_FLAGS, 32'h80);
    arr(10'h040);
    arr(10'h041);
    summarize();
  end
endmodule // tb_nor_page_sequencer
